/* tb/cck_cfg_ram.sv */
// Configuration memory model behind the readback port
`timescale 1ns/10ps
`default_nettype none

module cck_cfg_ram (
  // Clock
  input  wire logic        clk,
  // Readback request and answer
  input  wire logic        rd,
  input  wire logic [6:0]  addr,
  output logic      [15:0] rdata,
  // Content load and upset injection
  input  wire logic        wr_en,
  input  wire logic [6:0]  wr_addr,
  input  wire logic [15:0] wr_data
);
  logic [15:0] mem [128];

  // ==========================================================
  // Storage, written by the load stream and by upsets
  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  // Answer one cycle after the request; idle bus never repeats a word
  always_ff @(posedge clk) begin
    rdata <= rd ? mem[addr] : ~rdata;
  end
endmodule

`default_nettype wire

/* tb/cck_checker_test.sv */
// Self-checking testbench of the configuration memory checker
`timescale 1ns/10ps
`default_nettype none
`include "cck_map.svh"

module cck_checker_test;
  logic        clk, rst_n, rcfg_n, cfg_valid, cfg_last, cfg_error, user_mode;
  logic        ram_rd, crc_error, emr_valid, emr_ack, capture, shift, update;
  logic        tdi, tdo, wr_en;
  logic [15:0] cfg_data, ram_rdata, wr_data;
  logic [6:0]  ram_addr, wr_addr;
  logic [29:0] emr_data;
  logic [9:0]  ir_code;
  logic [15:0] img [128];
  logic [31:0] seed = 32'h3f12;
  int          err_count = 0;
  int          total_checks = 0;

  cck_checker u_cck_checker (
    .CLK(clk), .RESET_N(rst_n), .RECONFIG_REQUEST_N(rcfg_n), .CFG_VALID(cfg_valid),
    .CFG_LAST(cfg_last), .CFG_DATA(cfg_data), .CFG_ERROR(cfg_error), .USER_MODE(user_mode),
    .RAM_RD(ram_rd), .RAM_ADDR(ram_addr), .RAM_RDATA(ram_rdata), .CRC_ERROR(crc_error),
    .EMR_VALID(emr_valid), .EMR_DATA(emr_data), .CORE_EMR_ACK(emr_ack), .IR_CODE(ir_code),
    .CAPTURE_DR(capture), .SHIFT_DR(shift), .UPDATE_DR(update), .TDI(tdi), .TDO(tdo));
  cck_cfg_ram u_cck_cfg_ram (
    .clk(clk), .rd(ram_rd), .addr(ram_addr), .rdata(ram_rdata),
    .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data));

  // ==========================================================
  // Expectation helpers
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  function automatic logic [15:0] crc16(input logic [15:0] c, input logic [15:0] d);
    for (int i = 15; i >= 0; i--)
      c = {c[14:0], 1'b0} ^ ((c[15] ^ d[i]) ? 16'h8005 : 16'h0000);
    return c;
  endfunction
  // Signature left by an error pattern in one word of a frame
  function automatic logic [15:0] synd(input int w, input logic [15:0] m);
    logic [15:0] s;
    s = 16'h0000;
    for (int k = 0; k < 9; k++)
      s = crc16(s, (k == w) ? m : 16'h0000);
    return s;
  endfunction

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wrap_up();
    if (err_count == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // ==========================================================
  // Drivers
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic put(input int a, input logic [15:0] d);
    @(posedge clk);
    wr_en <= 1'b1;
    wr_addr <= 7'(a);
    wr_data <= d;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask
  task automatic ack();
    @(posedge clk);
    emr_ack <= 1'b1;
    @(posedge clk);
    emr_ack <= 1'b0;
  endtask
  // Stream 16 frames; frame bad carries a wrong check word
  task automatic load_all(input int bad);
    logic [15:0] c;
    logic [15:0] d;
    for (int f = 0; f < 16; f++) begin
      c = 16'h0000;
      for (int w = 0; w < 9; w++) begin
        seed = lfsr(seed);
        d = (w < 8) ? seed[15:0] : c ^ ((f == bad) ? 16'h0001 : 16'h0000);
        img[f*8+w] = d;
        c = crc16(c, d);
        @(posedge clk);
        cfg_valid <= 1'b1;
        cfg_last <= (w == 8);
        cfg_data <= d;
        wr_en <= (w < 8);
        wr_addr <= 7'(f*8+w);
        wr_data <= d;
      end
    end
    @(posedge clk);
    cfg_valid <= 1'b0;
    cfg_last <= 1'b0;
    wr_en <= 1'b0;
    cyc(2);
  endtask
  task automatic shift_fault(input logic [20:0] v);
    @(posedge clk);
    ir_code <= `CCK_IR_FAULT;
    capture <= 1'b1;
    @(posedge clk);
    capture <= 1'b0;
    for (int i = 0; i < 21; i++) begin
      shift <= 1'b1;
      tdi <= v[i];
      @(posedge clk);
    end
    shift <= 1'b0;
    update <= 1'b1;
    @(posedge clk);
    update <= 1'b0;
  endtask
  // Capture the error message and shift it out, LSB first
  task automatic shift_emr(output logic [29:0] v);
    @(posedge clk);
    ir_code <= `CCK_IR_EMR;
    capture <= 1'b1;
    @(posedge clk);
    capture <= 1'b0;
    shift <= 1'b1;
    @(posedge clk);
    for (int i = 0; i < 30; i++) begin
      @(posedge clk);
      v[i] = tdo;
    end
    shift <= 1'b0;
  endtask
  task automatic wait_flag(input int which);
    int k;
    k = 0;
    while (((which == 0) ? crc_error : emr_valid) !== 1'b1 && k < 1000) begin
      @(posedge clk);
      k++;
    end
  endtask

  // ==========================================================
  // Clock, watchdog and main sequence
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    cyc(40000);
    err_count++;
    wrap_up();
  end
  initial begin
    int f, w, p, a, t, b, sh;
    logic [15:0] m;
    logic [29:0] e, v;
    {rst_n, cfg_valid, cfg_last, emr_ack, capture, shift, update, tdi, wr_en} = '0;
    {rcfg_n, cfg_data, wr_data, wr_addr, ir_code} = {1'b1, 49'h0};
    cyc(16);
    rst_n <= 1'b1;
    cyc(2);
    load_all(3);
    check(cfg_error, 1'b1);
    check(user_mode, 1'b0);
    rcfg_n <= 1'b0;
    cyc(4);
    rcfg_n <= 1'b1;
    cyc(3);
    check(cfg_error, 1'b0);
    shift_fault(21'h080010);
    load_all(16);
    check(user_mode, 1'b1);
    cyc(400);
    check({crc_error, emr_valid}, 2'b00);
    // Single, adjacent double and triple upsets in random places
    for (int i = 0; i < 3; i++) begin
      seed = lfsr(seed);
      f = int'(seed[19:16]) % 15;
      w = int'(seed[2:0]);
      p = int'(seed[7:4]) % 14;
      a = f*8 + w;
      m = 16'((i == 0) ? 1 : (i == 1) ? 3 : 7) << p;
      put(a, img[a] ^ m);
      wait_flag(0);
      check(crc_error, 1'b1);
      wait_flag(1);
      check({emr_data[27:24], emr_data[15:0]}, {4'(f), synd(w, m)});
      if (i < 2) begin
        check(emr_data[29:16], {2'(i + 1), 4'(f), 8'(w*16 + 15 - p - i)});
      end
      put(a, img[a]);
      cyc(600);
      ack();
      cyc(400);
      check({crc_error, emr_valid}, 2'b00);
    end
    // Every injection type in turn, ending with none
    for (int i = 0; i < 4; i++) begin
      t = (i + 1) % 4;
      seed = lfsr(seed);
      b = int'(seed[3:0]);
      sh = b[0] ? 0 : 8;
      m = 16'((t == 2) ? 8'h30 : 8'h10) << sh;
      shift_fault({2'(t), 7'h00, 4'(b), (t == 2) ? 8'h30 : 8'h10});
      cyc(400);
      ack();
      cyc(400);
      if (t == 1 || t == 2) begin
        e = {2'(t), 4'h0, 8'((b / 2)*16 + 15 - sh - 4 - (t - 1)), synd(b / 2, m)};
        check(emr_data, e);
        check(emr_valid, 1'b1);
        shift_emr(v);
        check(v, e);
      end else begin
        check({crc_error, emr_valid}, 2'b00);
      end
    end
    wrap_up();
  end
endmodule

`default_nettype wire

/* tb/cck_port_checker.sv */
// Port-level assertions for the configuration memory checker
`timescale 1ns/10ps
`default_nettype none
`include "cck_map.svh"

module cck_port_checker (
  // Clock and reset
  input  wire logic        CLK,
  input  wire logic        RESET_N,
  input  wire logic        RECONFIG_REQUEST_N,
  // Load stream
  input  wire logic        CFG_VALID,
  input  wire logic        CFG_LAST,
  input  wire logic        CFG_ERROR,
  input  wire logic        USER_MODE,
  // Readback and results
  input  wire logic        RAM_RD,
  input  wire logic [6:0]  RAM_ADDR,
  input  wire logic        CRC_ERROR,
  input  wire logic        EMR_VALID,
  input  wire logic [29:0] EMR_DATA,
  input  wire logic        CORE_EMR_ACK,
  input  wire logic [9:0]  IR_CODE,
  input  wire logic        CAPTURE_DR
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESET_N);

  // ==========================================================
  // Load phase
  a_halt_blocks_user: assert property (CFG_ERROR |-> !USER_MODE)
    else $error("user mode entered after a halted load");
  a_halt_holds: assert property (CFG_ERROR && RECONFIG_REQUEST_N
    && $past(RECONFIG_REQUEST_N) && $past(RECONFIG_REQUEST_N, 2)
    && $past(RECONFIG_REQUEST_N, 3) |=> CFG_ERROR)
    else $error("load halt dropped without restart");
  a_user_on_last: assert property ($rose(USER_MODE) |-> $past(CFG_VALID && CFG_LAST))
    else $error("user mode without a final check word");

  // ==========================================================
  // Readback scan
  a_read_burst: assert property ($rose(RAM_RD) |-> RAM_RD [*8] ##1 !RAM_RD)
    else $error("readback burst not eight words");
  a_read_user: assert property (RAM_RD |-> USER_MODE)
    else $error("readback outside user mode");
  a_skip_memory: assert property (RAM_RD |-> RAM_ADDR[6:3] != 4'hf)
    else $error("skipped frame was read");
  a_flag_timing: assert property (USER_MODE && $changed(CRC_ERROR) |-> !RAM_RD
    && ($past(RAM_RD, 3) || $past(RAM_RD, 4) || $past(RAM_RD, 5)))
    else $error("error output moved outside a frame end");

  // ==========================================================
  // Error message
  a_msg_clear: assert property ($fell(EMR_VALID) |-> $past(CORE_EMR_ACK)
    || $past(CAPTURE_DR && IR_CODE == `CCK_IR_EMR)
    || !$past(RECONFIG_REQUEST_N, 2) || !$past(RECONFIG_REQUEST_N, 3))
    else $error("error message lost without a read");
  a_msg_typed: assert property ($rose(EMR_VALID) |-> EMR_DATA[29:28] != 2'b00
    && EMR_DATA[15:0] != 16'h0000)
    else $error("error message without class or signature");
endmodule

bind cck_checker cck_port_checker u_port_chk (
  .CLK(CLK), .RESET_N(RESET_N), .RECONFIG_REQUEST_N(RECONFIG_REQUEST_N),
  .CFG_VALID(CFG_VALID), .CFG_LAST(CFG_LAST), .CFG_ERROR(CFG_ERROR),
  .USER_MODE(USER_MODE), .RAM_RD(RAM_RD), .RAM_ADDR(RAM_ADDR), .CRC_ERROR(CRC_ERROR),
  .EMR_VALID(EMR_VALID), .EMR_DATA(EMR_DATA), .CORE_EMR_ACK(CORE_EMR_ACK),
  .IR_CODE(IR_CODE), .CAPTURE_DR(CAPTURE_DR));

`default_nettype wire

/* verilog/cck_checker.sv */
// Configuration memory integrity checker: load-time and run-time CRC
// ==========================================================
`timescale 1ns/10ps
`default_nettype none
`include "cck_map.svh"

module cck_checker
  import cck_pkg::*;
(
  // Clock and reset
  input  wire logic                    CLK,
  input  wire logic                    RESET_N,
  // Restart pin
  input  wire logic                    RECONFIG_REQUEST_N,
  // Load stream
  input  wire logic                    CFG_VALID,
  input  wire logic                    CFG_LAST,
  input  wire logic [`CCK_CRC_W-1:0]   CFG_DATA,
  output logic                         CFG_ERROR,
  output logic                         USER_MODE,
  // Configuration memory readback
  output logic                         RAM_RD,
  output logic      [`CCK_RAM_AW-1:0]  RAM_ADDR,
  input  wire logic [`CCK_CRC_W-1:0]   RAM_RDATA,
  // Error output
  output logic                         CRC_ERROR,
  // Core side error message access
  output logic                         EMR_VALID,
  output logic      [`CCK_EMR_W-1:0]   EMR_DATA,
  input  wire logic                    CORE_EMR_ACK,
  // Test access data path
  input  wire logic [`CCK_IR_W-1:0]    IR_CODE,
  input  wire logic                    CAPTURE_DR,
  input  wire logic                    SHIFT_DR,
  input  wire logic                    UPDATE_DR,
  input  wire logic                    TDI,
  output logic                         TDO
);

  // ==========================================================
  // Declarations
  cck_state_t                state_reg;
  logic                      rcfg_s1_reg;
  logic                      rcfg_s2_reg;
  logic                      restart;
  logic [`CCK_FRAME_AW-1:0]  frame_reg;
  logic [`CCK_WORD_AW-1:0]   word_reg;
  logic                      pipe_vld_reg;
  logic                      pipe_last_reg;
  logic [`CCK_WORD_AW-1:0]   pipe_word_reg;
  logic [`CCK_CRC_W-1:0]     crc_reg;
  logic [`CCK_CRC_W-1:0]     chk_rd;
  logic [`CCK_CRC_W-1:0]     signature;
  logic [`CCK_CRC_W-1:0]     inj_mask;
  logic                      skip_frame;
  logic [`CCK_FRAMES-1:0]    skip_vec;
  logic                      chk_wr;
  logic                      loc_start;
  logic                      loc_busy;
  logic                      loc_done;
  cck_err_t                  loc_type;
  logic [`CCK_BIT_AW-1:0]    loc_bit;
  logic [`CCK_CRC_W-1:0]     err_syn_reg;
  logic [`CCK_FRAME_AW-1:0]  err_frame_reg;
  logic [`CCK_FI_W-1:0]      fi_reg;
  logic [`CCK_FI_W-1:0]      fi_sr_reg;
  logic [`CCK_EMR_W-1:0]     emr_sr_reg;
  logic                      sel_fault;
  logic                      sel_emr;
  logic                      inj_on;
  logic [7:0]                inj_val;
  logic [`CCK_FI_BYTE_HI-`CCK_FI_BYTE_LO:0] inj_byte;

  // ==========================================================
  // Restart pin synchroniser
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      // Idle level of the pin, so no false restart follows reset
      rcfg_s1_reg <= 1'b1;
      rcfg_s2_reg <= 1'b1;
    end else begin
      rcfg_s1_reg <= RECONFIG_REQUEST_N;
      rcfg_s2_reg <= rcfg_s1_reg;
    end
  end

  assign restart = !rcfg_s2_reg;

  // ==========================================================
  // Combinational helpers
  assign skip_vec   = `CCK_SKIP_MASK;
  assign skip_frame = skip_vec[frame_reg];
  assign signature  = cck_crc_word(crc_reg, chk_rd);
  assign chk_wr     = state_reg == ST_CFG && CFG_VALID && CFG_LAST
                      && CFG_DATA == crc_reg;
  assign loc_start  = state_reg == ST_SIG && signature != '0;
  assign sel_fault  = IR_CODE == `CCK_IR_FAULT;
  assign sel_emr    = IR_CODE == `CCK_IR_EMR;
  assign inj_val    = fi_reg[`CCK_FI_VAL_HI:0];
  assign inj_byte   = fi_reg[`CCK_FI_BYTE_HI:`CCK_FI_BYTE_LO];
  // Only 01 and 10 inject; 11 decodes as none
  assign inj_on     = fi_reg[`CCK_FI_TYPE_HI] ^ fi_reg[`CCK_FI_TYPE_LO];

  always_comb begin
    inj_mask = '0;
    if (inj_on && frame_reg == '0 && pipe_word_reg == inj_byte[3:1]) begin
      inj_mask = inj_byte[0] ? {8'h00, inj_val} : {inj_val, 8'h00};
    end
  end

  // ==========================================================
  // Main sequencer
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      state_reg <= ST_CFG;
      frame_reg <= '0;
      word_reg  <= '0;
      USER_MODE <= 1'b0;
      CFG_ERROR <= 1'b0;
      RAM_RD    <= 1'b0;
      RAM_ADDR  <= '0;
    end else if (restart) begin
      state_reg <= ST_CFG;
      frame_reg <= '0;
      word_reg  <= '0;
      USER_MODE <= 1'b0;
      CFG_ERROR <= 1'b0;
      RAM_RD    <= 1'b0;
    end else begin
      unique case (state_reg)
        ST_CFG: begin
          if (CFG_VALID && CFG_LAST) begin
            if (CFG_DATA != crc_reg) begin
              state_reg <= ST_CFG_FAIL;
              CFG_ERROR <= 1'b1;
            end else if (frame_reg == `CCK_LAST_FRAME) begin
              state_reg <= ST_SEL;
              frame_reg <= '0;
              USER_MODE <= 1'b1;
            end else begin
              frame_reg <= frame_reg + 4'h1;
            end
          end
        end
        ST_CFG_FAIL: begin
          state_reg <= ST_CFG_FAIL;
        end
        ST_SEL: begin
          if (skip_frame) begin
            frame_reg <= frame_reg + 4'h1;
          end else begin
            state_reg <= ST_RD;
            word_reg  <= '0;
          end
        end
        ST_RD: begin
          RAM_RD   <= 1'b1;
          RAM_ADDR <= {frame_reg, word_reg};
          word_reg <= word_reg + 3'h1;
          if (word_reg == `CCK_LAST_WORD) begin
            state_reg <= ST_DRAIN;
          end
        end
        ST_DRAIN: begin
          RAM_RD <= 1'b0;
          if (pipe_vld_reg && pipe_last_reg) begin
            state_reg <= ST_SIG;
          end
        end
        ST_SIG: begin
          // Next frame follows whatever this one showed
          state_reg <= ST_SEL;
          frame_reg <= frame_reg + 4'h1;
        end
        default: begin
          state_reg <= ST_CFG;
        end
      endcase
    end
  end

  // ==========================================================
  // Readback data pipeline: data return one cycle after the read
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      pipe_vld_reg  <= 1'b0;
      pipe_last_reg <= 1'b0;
      pipe_word_reg <= '0;
    end else begin
      pipe_vld_reg  <= RAM_RD && !restart;
      pipe_last_reg <= RAM_ADDR[`CCK_WORD_AW-1:0] == `CCK_LAST_WORD;
      pipe_word_reg <= RAM_ADDR[`CCK_WORD_AW-1:0];
    end
  end

  // ==========================================================
  // Running code over load stream and readback
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      crc_reg <= '0;
    end else if (restart) begin
      crc_reg <= '0;
    end else if (state_reg == ST_CFG && CFG_VALID) begin
      crc_reg <= CFG_LAST ? '0 : cck_crc_word(crc_reg, CFG_DATA);
    end else if (pipe_vld_reg) begin
      crc_reg <= cck_crc_word(crc_reg, RAM_RDATA ^ inj_mask);
    end else if (state_reg == ST_SIG) begin
      crc_reg <= '0;
    end
  end

  // ==========================================================
  // Error output: level of the last checked frame, held over skips
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      CRC_ERROR <= 1'b0;
    end else if (restart) begin
      CRC_ERROR <= 1'b0;
    end else if (state_reg == ST_SIG) begin
      CRC_ERROR <= signature != '0;
    end
  end

  // ==========================================================
  // Locator request; a busy locator lets the new error go unlocated
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      err_syn_reg   <= '0;
      err_frame_reg <= '0;
    end else if (loc_start && !loc_busy) begin
      err_syn_reg   <= signature;
      err_frame_reg <= frame_reg;
    end
  end

  // ==========================================================
  // Error message register: fresh result wins over a read in the same cycle
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      EMR_DATA  <= `CCK_EMR_RST;
      EMR_VALID <= 1'b0;
    end else if (restart) begin
      EMR_VALID <= 1'b0;
    end else if (loc_done) begin
      EMR_DATA  <= {loc_type, err_frame_reg, loc_bit, err_syn_reg};
      EMR_VALID <= 1'b1;
    end else if (CORE_EMR_ACK || (CAPTURE_DR && sel_emr)) begin
      EMR_VALID <= 1'b0;
    end
  end

  // ==========================================================
  // Test access shift paths
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      emr_sr_reg <= `CCK_EMR_RST;
    end else if (sel_emr && CAPTURE_DR) begin
      emr_sr_reg <= EMR_DATA;
    end else if (sel_emr && SHIFT_DR) begin
      emr_sr_reg <= {TDI, emr_sr_reg[`CCK_EMR_W-1:1]};
    end
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      fi_sr_reg <= `CCK_FI_RST;
    end else if (sel_fault && CAPTURE_DR) begin
      fi_sr_reg <= fi_reg;
    end else if (sel_fault && SHIFT_DR) begin
      fi_sr_reg <= {TDI, fi_sr_reg[`CCK_FI_W-1:1]};
    end
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      fi_reg <= `CCK_FI_RST;
    end else if (restart) begin
      fi_reg <= `CCK_FI_RST;
    end else if (sel_fault && UPDATE_DR && USER_MODE) begin
      fi_reg <= fi_sr_reg;
    end
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      TDO <= 1'b0;
    end else begin
      TDO <= sel_fault ? fi_sr_reg[0] : (sel_emr ? emr_sr_reg[0] : 1'b0);
    end
  end

  // ==========================================================
  // Submodules
  cck_chk_mem u_chk_mem (
    .clk     (CLK),
    .wr_en   (chk_wr),
    .wr_addr (frame_reg),
    .wr_data (CFG_DATA),
    .rd_addr (frame_reg),
    .rd_data (chk_rd)
  );

  cck_locator u_locator (
    .clk      (CLK),
    .rst_n    (RESET_N),
    .restart  (restart),
    .start    (loc_start && !loc_busy),
    .syndrome (signature),
    .busy     (loc_busy),
    .done     (loc_done),
    .err_type (loc_type),
    .loc      (loc_bit)
  );

endmodule
`default_nettype wire

/* verilog/cck_chk_mem.sv */
// Check bit store: one 16-bit word per frame, registered read
`timescale 1ns/10ps
`default_nettype none
`include "cck_map.svh"

module cck_chk_mem
  import cck_pkg::*;
(
  // Clock
  input  wire logic                     clk,
  // Write side
  input  wire logic                     wr_en,
  input  wire logic [`CCK_FRAME_AW-1:0] wr_addr,
  input  wire logic [`CCK_CRC_W-1:0]    wr_data,
  // Read side
  input  wire logic [`CCK_FRAME_AW-1:0] rd_addr,
  output logic      [`CCK_CRC_W-1:0]    rd_data
);

  logic [`CCK_CRC_W-1:0] mem [`CCK_FRAMES];

  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge clk) begin
    rd_data <= mem[rd_addr];
  end

endmodule
`default_nettype wire

/* verilog/cck_locator.sv */
// Error locator: walks single and adjacent-pair syndromes of one frame
`timescale 1ns/10ps
`default_nettype none
`include "cck_map.svh"

module cck_locator
  import cck_pkg::*;
(
  // Clock and reset
  input  wire logic                   clk,
  input  wire logic                   rst_n,
  input  wire logic                   restart,
  // Request
  input  wire logic                   start,
  input  wire logic [`CCK_CRC_W-1:0]  syndrome,
  // Result
  output logic                        busy,
  output logic                        done,
  output cck_err_t                    err_type,
  output logic      [`CCK_BIT_AW-1:0] loc
);

  logic [`CCK_CRC_W-1:0]  syn_reg;
  logic [`CCK_CRC_W-1:0]  s_cur_reg;
  logic [`CCK_CRC_W-1:0]  s_prev_reg;
  logic [`CCK_BIT_AW-1:0] k_reg;

  // Position k counts back from the last bit; its syndrome is x^(k+16)
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busy       <= 1'b0;
      done       <= 1'b0;
      err_type   <= ET_NONE;
      loc        <= '0;
      syn_reg    <= '0;
      s_cur_reg  <= '0;
      s_prev_reg <= '0;
      k_reg      <= '0;
    end else if (restart) begin
      busy <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start && !busy) begin
        busy       <= 1'b1;
        syn_reg    <= syndrome;
        s_cur_reg  <= `CCK_POLY;
        s_prev_reg <= '0;
        k_reg      <= '0;
      end else if (busy) begin
        if (s_cur_reg == syn_reg) begin
          busy     <= 1'b0;
          done     <= 1'b1;
          err_type <= ET_SINGLE;
          loc      <= `CCK_LAST_BIT - k_reg;
        end else if (k_reg != '0 && (s_cur_reg ^ s_prev_reg) == syn_reg) begin
          busy     <= 1'b0;
          done     <= 1'b1;
          err_type <= ET_DOUBLE;
          loc      <= `CCK_LAST_BIT - k_reg;
        end else if (k_reg == `CCK_LAST_BIT) begin
          busy     <= 1'b0;
          done     <= 1'b1;
          err_type <= ET_OTHER;
          loc      <= '0;
        end else begin
          k_reg      <= k_reg + 8'h01;
          s_prev_reg <= s_cur_reg;
          s_cur_reg  <= cck_mulx(s_cur_reg);
        end
      end
    end
  end

endmodule
`default_nettype wire

/* verilog/cck_map.svh */
// Constants of the configuration memory check block
`ifndef CCK_MAP_SVH
`define CCK_MAP_SVH

// ==========================================================
// Frame geometry
`define CCK_FRAMES      16
`define CCK_FRAME_AW    4
`define CCK_WORDS       8
`define CCK_WORD_AW     3
`define CCK_LAST_FRAME  4'hf
`define CCK_LAST_WORD   3'h7
`define CCK_RAM_AW      7
`define CCK_SKIP_MASK   16'h8000

// ==========================================================
// Check code
`define CCK_CRC_W       16
`define CCK_POLY        16'h8005
`define CCK_BIT_AW      8
`define CCK_LAST_BIT    8'h8f

// ==========================================================
// Test access instructions and fault injection register
`define CCK_IR_W        10
`define CCK_IR_FAULT    10'h015
`define CCK_IR_EMR      10'h017
`define CCK_FI_W        21
`define CCK_FI_TYPE_HI  20
`define CCK_FI_TYPE_LO  19
`define CCK_FI_BYTE_HI  11
`define CCK_FI_BYTE_LO  8
`define CCK_FI_VAL_HI   7
`define CCK_FI_RST      21'h000000

// ==========================================================
// Error message register
`define CCK_EMR_W       30
`define CCK_EMR_RST     30'h00000000

`endif

/* verilog/cck_pkg.sv */
// Types and check code arithmetic of the configuration memory check block
`default_nettype none
`include "cck_map.svh"

package cck_pkg;

  // ==========================================================
  // Main sequencer states
  typedef enum logic [2:0] {
    ST_CFG      = 3'b000,
    ST_CFG_FAIL = 3'b001,
    ST_SEL      = 3'b010,
    ST_RD       = 3'b011,
    ST_DRAIN    = 3'b100,
    ST_SIG      = 3'b101
  } cck_state_t;

  // Error classes held in the error message register
  typedef enum logic [1:0] {
    ET_NONE   = 2'b00,
    ET_SINGLE = 2'b01,
    ET_DOUBLE = 2'b10,
    ET_OTHER  = 2'b11
  } cck_err_t;

  // ==========================================================
  // One 16-bit word through the code, MSB first
  function automatic logic [15:0] cck_crc_word(input logic [15:0] crc,
                                               input logic [15:0] data);
    logic [15:0] c;
    logic        fb;
    c = crc;
    for (int i = 15; i >= 0; i--) begin
      fb = c[15] ^ data[i];
      c  = {c[14:0], 1'b0};
      if (fb) begin
        c = c ^ `CCK_POLY;
      end
    end
    return c;
  endfunction

  // Multiply a remainder by x
  function automatic logic [15:0] cck_mulx(input logic [15:0] s);
    logic [15:0] c;
    c = {s[14:0], 1'b0};
    if (s[15]) begin
      c = c ^ `CCK_POLY;
    end
    return c;
  endfunction

endpackage
`default_nettype wire
